/* File: rtl/dbt_top.sv */
// Top of the dual basic timer: configuration, interrupt paths and two cores.
`timescale 1ns/1ps
module dbt_top (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [3:0] src_tick,
    input wire logic cfg_write,
    input wire logic cfg_select,
    input wire dbt_pkg::dbt_src_t clock_source_select,
    input wire logic [dbt_pkg::DBT_DIV_W-1:0] divide_factor,
    input wire logic [dbt_pkg::DBT_CNT_W-1:0] count_value,
    input wire logic irq_polarity,
    input wire dbt_pkg::dbt_trig_t irq_trigger_select,
    input wire dbt_pkg::dbt_kind_t irq_kind_select,
    input wire logic [1:0] run_enable_set,
    input wire logic [1:0] run_enable_clear,
    input wire logic [1:0] irq_enable_set,
    input wire logic [1:0] irq_enable_clear,
    input wire logic [1:0] status_clear,
    output logic [1:0] run_enabled,
    output logic [1:0] irq_enabled,
    output logic [1:0] irq_status,
    output logic [1:0] irq_maskable,
    output logic [1:0] irq_non_maskable,
    output logic [1:0] wakeup_request,
    output logic [15:0] count_now
);
    import dbt_pkg::*;

    // ==========================================================================
    // Per-timer configuration and interrupt logic
    // ==========================================================================
    for (genvar t = 0; t < DBT_NUM_TIMERS; t++) begin : g_tmr
        dbt_cfg_if cif ();
        logic run_reg;
        logic ien_reg;
        logic stat_reg;
        logic stat_dly_reg;
        logic pol_reg;
        dbt_src_t src_reg;
        dbt_trig_t trig_reg;
        dbt_kind_t kind_reg;
        logic [DBT_DIV_W-1:0] div_reg;
        logic [DBT_CNT_W-1:0] cnt_reg;
        logic [1:0] outs_reg;
        logic wake_reg;

        wire wr_this = cfg_write && (cfg_select == 1'(t));
        // Set wins over clear so that a terminal count is never lost.
        wire stat_next = cif.terminal_pulse || (stat_reg && !status_clear[t]);
        // The line seen by the interrupt controller follows the chosen polarity.
        wire line_level = stat_reg ^ !pol_reg;
        wire line_dly = stat_dly_reg ^ !pol_reg;
        wire edge_event = line_level && !line_dly;
        wire fire = (trig_reg == DBT_TRIG_EDGE) ? edge_event : line_level;
        wire req = fire && ien_reg && (kind_reg != DBT_KIND_POLLING_ONLY);

        assign cif.run_enable = run_reg;
        assign cif.clock_source_select = src_reg;
        assign cif.divide_factor = div_reg;
        assign cif.count_value = cnt_reg;

        always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
                run_reg <= 1'b0;
                ien_reg <= 1'b0;
                stat_reg <= 1'b0;
                stat_dly_reg <= 1'b0;
                pol_reg <= 1'b1;
                src_reg <= DBT_SRC_RESET;
                trig_reg <= DBT_TRIG_EDGE;
                kind_reg <= DBT_KIND_MASKABLE;
                div_reg <= DBT_DIV_RESET;
                cnt_reg <= DBT_CNT_RESET;
                outs_reg <= 2'h0;
                wake_reg <= 1'b0;
            end else if (clk_en) begin
                if (wr_this) begin
                    src_reg <= clock_source_select;
                    div_reg <= divide_factor;
                    cnt_reg <= count_value;
                    pol_reg <= irq_polarity;
                    trig_reg <= irq_trigger_select;
                    kind_reg <= irq_kind_select;
                end
                run_reg <= run_enable_set[t] || (run_reg && !run_enable_clear[t]);
                ien_reg <= irq_enable_set[t] || (ien_reg && !irq_enable_clear[t]);
                stat_reg <= stat_next;
                stat_dly_reg <= stat_reg;
                outs_reg[0] <= req && (kind_reg == DBT_KIND_MASKABLE);
                outs_reg[1] <= req && (kind_reg == DBT_KIND_NON_MASKABLE);
                wake_reg <= req && (trig_reg == DBT_TRIG_ASYNC_LEVEL_WAKEUP);
            end
        end

        assign run_enabled[t] = run_reg;
        assign irq_enabled[t] = ien_reg;
        assign irq_status[t] = stat_reg;
        assign irq_maskable[t] = outs_reg[0];
        assign irq_non_maskable[t] = outs_reg[1];
        assign wakeup_request[t] = wake_reg;
        assign count_now[t*8 +: 8] = cif.count_now;

        dbt_core u_core (
            .sys_clk(sys_clk),
            .rst_b(rst_b),
            .clk_en(clk_en),
            .src_tick(src_tick),
            .cfg(cif.core)
        );
    end

endmodule : dbt_top

/* File: inc/dbt_pkg.sv */
// Package with constants and types for the dual basic timer.
package dbt_pkg;

    // ==========================================================================
    // Widths and reset values
    // ==========================================================================
    localparam int DBT_NUM_TIMERS = 2;
    localparam int DBT_DIV_W = 8;
    localparam int DBT_CNT_W = 8;
    localparam logic [DBT_DIV_W-1:0] DBT_DIV_RESET = 8'h00;
    localparam logic [DBT_CNT_W-1:0] DBT_CNT_RESET = 8'h00;

    // ==========================================================================
    // Enumerations
    // ==========================================================================
    typedef enum logic [1:0] {
        DBT_SRC_FAST_INTERNAL_OSC = 2'h0,
        DBT_SRC_SLOW_INTERNAL_OSC = 2'h1,
        DBT_SRC_FAST_EXTERNAL_OSC = 2'h2,
        DBT_SRC_PLL = 2'h3
    } dbt_src_t;

    typedef enum logic [1:0] {
        DBT_TRIG_EDGE = 2'h0,
        DBT_TRIG_LEVEL = 2'h1,
        DBT_TRIG_ASYNC_LEVEL_WAKEUP = 2'h2
    } dbt_trig_t;

    typedef enum logic [1:0] {
        DBT_KIND_MASKABLE = 2'h0,
        DBT_KIND_NON_MASKABLE = 2'h1,
        DBT_KIND_POLLING_ONLY = 2'h2
    } dbt_kind_t;

    localparam dbt_src_t DBT_SRC_RESET = DBT_SRC_FAST_INTERNAL_OSC;

endpackage : dbt_pkg

/* File: inc/dbt_cfg_if.sv */
// Interface carrying one timer's configuration and events.
`timescale 1ns/1ps
interface dbt_cfg_if;
    import dbt_pkg::*;
    logic run_enable;
    dbt_src_t clock_source_select;
    logic [DBT_DIV_W-1:0] divide_factor;
    logic [DBT_CNT_W-1:0] count_value;
    logic terminal_pulse;
    logic [DBT_CNT_W-1:0] count_now;
    modport ctrl (output run_enable, clock_source_select, divide_factor, count_value,
                  input terminal_pulse, count_now);
    modport core (input run_enable, clock_source_select, divide_factor, count_value,
                  output terminal_pulse, count_now);
endinterface : dbt_cfg_if

/* File: rtl/dbt_core.sv */
// One timer counting core with source select and divider.
`timescale 1ns/1ps
module dbt_core (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [3:0] src_tick,
    dbt_cfg_if.core cfg
);
    import dbt_pkg::*;

    // ==========================================================================
    // Source selection and divider
    // ==========================================================================
    logic [DBT_DIV_W-1:0] div_reg;
    logic [DBT_DIV_W-1:0] div_next;
    logic [DBT_CNT_W-1:0] cnt_reg;
    logic [DBT_CNT_W-1:0] cnt_next;
    logic pulse_reg;
    wire sel_tick = src_tick[cfg.clock_source_select];
    // A divide factor of zero passes every source tick through.
    wire div_wrap = sel_tick && (div_reg >= cfg.divide_factor);
    wire base_tick = cfg.run_enable && div_wrap;
    wire cnt_hit = base_tick && (cnt_reg >= cfg.count_value);

    assign div_next = !cfg.run_enable ? DBT_DIV_RESET :
                      !sel_tick ? div_reg :
                      div_wrap ? DBT_DIV_RESET : div_reg + 8'h01;
    assign cnt_next = !cfg.run_enable ? DBT_CNT_RESET :
                      !base_tick ? cnt_reg :
                      cnt_hit ? DBT_CNT_RESET : cnt_reg + 8'h01;
    assign cfg.terminal_pulse = pulse_reg;
    assign cfg.count_now = cnt_reg;

    // ==========================================================================
    // State
    // ==========================================================================
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            div_reg <= DBT_DIV_RESET;
            cnt_reg <= DBT_CNT_RESET;
            pulse_reg <= 1'b0;
        end else if (clk_en) begin
            div_reg <= div_next;
            cnt_reg <= cnt_next;
            pulse_reg <= cnt_hit;
        end
    end

endmodule : dbt_core

/* File: sim/dbt_props.sv */
// Port checker for the dual basic timer.
`timescale 1ns/1ps
module dbt_props (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic cfg_write,
    input wire logic [1:0] run_enable_set,
    input wire logic [1:0] run_enable_clear,
    input wire logic [1:0] irq_enable_set,
    input wire logic [1:0] status_clear,
    input wire logic [1:0] run_enabled,
    input wire logic [1:0] irq_enabled,
    input wire logic [1:0] irq_status,
    input wire logic [1:0] irq_maskable,
    input wire logic [1:0] irq_non_maskable,
    input wire logic [15:0] count_now
);
    // ==========
    // Properties
    // ==========
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // A config write may reload a count, so it stays out of the idle window.
    sequence s_idle1;
        (!run_enabled[1] && !cfg_write) [*3];
    endsequence
    AST_RUN_ON: assert property (clk_en && run_enable_set[0] |=> run_enabled[0])
        else $error("run set lost");
    AST_RUN_OFF: assert property (clk_en && run_enable_clear[1] && !run_enable_set[1] |=> !run_enabled[1])
        else $error("run clear lost");
    AST_IEN_ON: assert property (clk_en && irq_enable_set[1] |=> irq_enabled[1])
        else $error("irq enable lost");
    AST_STILL: assert property (s_idle1 ##1 !run_enabled[1] |-> $stable(count_now[15:8]))
        else $error("idle timer counts");
    AST_STS_FALL: assert property ($fell(irq_status[0]) |-> $past(status_clear[0]))
        else $error("status lost");
    AST_STS_RISE: assert property ($rose(irq_status[0]) |-> $past(run_enabled[0], 2))
        else $error("status from idle timer");
    AST_REQ: assert property (irq_maskable[0] |-> $past(irq_status[0] && irq_enabled[0]))
        else $error("ungated request");
    AST_NMI: assert property (irq_non_maskable[0] |-> $past(irq_status[0] && irq_enabled[0]))
        else $error("ungated nmi");
    AST_EXCL: assert property ((irq_maskable & irq_non_maskable) == 2'h0)
        else $error("two kinds at once");
    AST_RST: assert property (disable iff (1'b0) !rst_b |=> irq_status == 2'h0 && run_enabled == 2'h0)
        else $error("reset left state");
endmodule : dbt_props
bind dbt_top dbt_props u_props (.*);

/* File: sim/dbt_top_bench.sv */
// Self-checking bench for the dual basic timer.
`timescale 1ns/1ps
module dbt_top_bench;
    import dbt_pkg::*;
    logic sys_clk = 1'h0, rst_b = 1'h0, clk_en = 1'h1, cfg_write = 1'h0, cfg_select = 1'h0;
    logic irq_polarity = 1'h1;
    logic [3:0] src_tick = 4'h0;
    dbt_src_t clock_source_select = DBT_SRC_RESET;
    dbt_trig_t irq_trigger_select = DBT_TRIG_EDGE;
    dbt_kind_t irq_kind_select = DBT_KIND_MASKABLE;
    logic [7:0] divide_factor = 8'h00, count_value = 8'h00;
    logic [1:0] run_enable_set = 2'h0, run_enable_clear = 2'h0, status_clear = 2'h0;
    logic [1:0] irq_enable_set = 2'h0, irq_enable_clear = 2'h0;
    logic [1:0] run_enabled, irq_enabled, irq_status, irq_maskable, irq_non_maskable;
    logic [1:0] wakeup_request;
    logic [15:0] count_now, held;
    int n_mismatch = 0, checks_done = 0, cyc = 0, n;
    dbt_top dut (.*);
    // ==========
    // Stimulus
    // ==========
    initial forever #2 sys_clk = ~sys_clk;
    // Source k ticks every k+1 cycles, so a wrong source shows as a wrong period.
    always @(negedge sys_clk) begin
        cyc <= cyc + 1;
        for (int k = 0; k < 4; k++) src_tick[k] <= (cyc % (k + 1)) == 0;
        if (cyc > 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wait_sts(input int t);
        n = 0;
        while (irq_status[t] !== 1'h1 && n < 4000) begin
            @(negedge sys_clk);
            n++;
        end
    endtask : wait_sts
    task run_case(input int t, s, d, c, g, k, input logic ien, input int per);
        cfg_select = t[0];
        clock_source_select = dbt_src_t'(s);
        divide_factor = d[7:0];
        count_value = c[7:0];
        irq_trigger_select = dbt_trig_t'(g);
        irq_kind_select = dbt_kind_t'(k);
        cfg_write = 1'h1;
        irq_enable_set[t] = ien;
        irq_enable_clear[t] = !ien;
        run_enable_set[t] = 1'h1;
        for (int i = 0; i < 2; i++) begin
            @(negedge sys_clk);
            {cfg_write, irq_enable_set, irq_enable_clear, run_enable_set} = 7'h00;
            status_clear[t] = 1'h1;
            @(negedge sys_clk);
            status_clear = 2'h0;
            wait_sts(t);
        end
        chk(16'(n + 2), 16'(per));
        @(negedge sys_clk);
        chk({irq_non_maskable[t], irq_maskable[t]}, {ien && k == 1, ien && k == 0});
        chk(wakeup_request[t], ien && g == 2);
    endtask : run_case
    task conclude;
        $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    initial begin
        repeat (10) @(negedge sys_clk);
        chk({run_enabled, irq_enabled, irq_status, count_now[9:0]}, 16'h0000);
        rst_b = 1'h1;
        for (int k = 0; k < 4; k++) run_case(0, k, 0, 3, k % 3, (k + 1) % 3, 1, 4 * (k + 1));
        run_case(1, 3, 2, 3, 1, 0, 0, 48);
        run_enable_clear = 2'h3;
        irq_enable_set = 2'h2;
        repeat (4) @(negedge sys_clk);
        {run_enable_clear, irq_enable_set, status_clear} = 6'h01;
        @(negedge sys_clk);
        status_clear = 2'h0;
        held = count_now;
        chk({run_enabled, irq_enabled, irq_status}, 6'h0E);
        repeat (16) @(negedge sys_clk);
        chk(count_now, held);
        clk_en = 1'h0;
        run_enable_set = 2'h3;
        repeat (3) @(negedge sys_clk);
        chk(16'(run_enabled), 16'h0000);
        {clk_en, run_enable_set} = 3'h4;
        @(negedge sys_clk);
        rst_b = 1'h0;
        repeat (2) @(negedge sys_clk);
        chk({run_enabled, irq_enabled, irq_status, count_now[9:0]}, 16'h0000);
        conclude();
    end
endmodule : dbt_top_bench
